// >>> hw/nsl_sequencer.sv
// Network status indicator sequencer with its APB register slave.
//
// Behaviour
// - Steady green when online and all connected.
// - Green 1 Hz flash when online, unconnected.
// - Flash is 500 ms lit, 500 ms dark.
// - Power-on test: green 250 ms, red 250 ms.
// - Red 1 Hz flash on minor fault, timeout.
// - Steady red on duplicate address or bus-off.
// - Dark while not online or no power.
// - Steady and dark states never interrupted.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module nsl_sequencer
    import nsl_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    output var  logic        LED_GREEN,
    output var  logic        LED_RED
);

    logic           [TICK_W-1:0] tick_cnt_ff;
    logic           [TICK_W-1:0] nxt_tick_cnt;
    logic                        tick_ff;
    logic                        nxt_tick;
    nsl_status_type              stat_ff;
    nsl_status_type              nxt_stat;
    logic           [31:0]       prdata_ff;
    logic           [31:0]       nxt_prdata;
    logic                        pready_ff;
    logic                        nxt_pready;
    logic                        pslverr_ff;
    logic                        nxt_pslverr;
    nsl_test_type                st_ff;
    nsl_test_type                nxt_st;
    logic           [MS_W-1:0]   st_cnt_ff;
    logic           [MS_W-1:0]   nxt_st_cnt;
    nsl_mode_type                mode_ff;
    nsl_mode_type                nxt_mode;
    logic           [MS_W-1:0]   phase_ff;
    logic           [MS_W-1:0]   nxt_phase;
    nsl_led_type                 led_ff;
    nsl_led_type                 nxt_led;
    logic                        lit;
    logic                        minor;
    logic                        offline;
    logic                        setup;
    logic                        wr_done;
    logic                        hit_status;
    logic                        hit_view;

    // Outputs come straight from flip-flops.
    assign PRDATA    = prdata_ff;
    assign PREADY    = pready_ff;
    assign PSLVERR   = pslverr_ff;
    assign LED_GREEN = led_ff.green;
    assign LED_RED   = led_ff.red;

    // Millisecond tick generator.
    // It restarts with every pattern change, so the first lit phase of a flash is a whole 500 ms.
    // The start value is one ahead because the tick pulse itself is registered once more.
    // A pending tick is dropped on a restart; otherwise the new phase would begin one tick short.
    always_comb
    begin
        nxt_tick     = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 1'b1;
        if (nxt_mode != mode_ff)
        begin
            nxt_tick_cnt = TICK_W'(TICK_START);
        end
        else if (tick_cnt_ff == TICK_W'(TICK_CYC - 1))
        begin
            nxt_tick_cnt = '0;
            nxt_tick     = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            tick_cnt_ff <= TICK_W'(TICK_START);
            tick_ff     <= 1'b0;
        end
        else
        begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff     <= nxt_tick;
        end
    end

    // APB decode: zero wait states, error on unmapped or read-only write.
    assign setup      = PSEL & ~PENABLE;
    assign hit_status = (PADDR == REG_STATUS_OFS);
    assign hit_view   = (PADDR == REG_VIEW_OFS);
    assign wr_done    = PSEL & PENABLE & pready_ff & PWRITE & ~pslverr_ff;

    // APB answer and status register.
    always_comb
    begin
        nxt_pready  = setup;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        nxt_stat    = stat_ff;
        if (setup)
        begin
            nxt_prdata  = '0;
            nxt_pslverr = ~(hit_status | (hit_view & ~PWRITE));
            if (!PWRITE && hit_status)
            begin
                nxt_prdata[STATUS_W-1:0] = stat_ff;
            end
            else if (!PWRITE && hit_view)
            begin
                nxt_prdata[VIEW_MODE_LSB+:3]  = mode_ff;
                nxt_prdata[VIEW_TEST_BIT]     = (st_ff != NSL_ST_DONE);
                nxt_prdata[VIEW_GREEN_BIT]    = led_ff.green;
                nxt_prdata[VIEW_RED_BIT]      = led_ff.red;
            end
        end
        if (wr_done && hit_status)
        begin
            nxt_stat = nsl_status_type'(PWDATA[STATUS_W-1:0]);
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            stat_ff    <= STATUS_RST;
        end
        else
        begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
            stat_ff    <= nxt_stat;
        end
    end

    // Power-on self-test sequencer, counted in milliseconds.
    always_comb
    begin
        nxt_st     = st_ff;
        nxt_st_cnt = st_cnt_ff;
        case (st_ff)
            NSL_ST_GREEN,
            NSL_ST_RED:
            begin
                if (tick_ff)
                begin
                    nxt_st_cnt = st_cnt_ff + 1'b1;
                    if (st_cnt_ff == MS_W'(SELFTEST_MS - 1))
                    begin
                        nxt_st_cnt = '0;
                        nxt_st     = (st_ff == NSL_ST_GREEN) ? NSL_ST_RED : NSL_ST_DONE;
                    end
                end
            end
            NSL_ST_DONE: nxt_st = NSL_ST_DONE;
            default:     nxt_st = NSL_ST_DONE;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            st_ff     <= NSL_ST_GREEN;
            st_cnt_ff <= '0;
        end
        else
        begin
            st_ff     <= nxt_st;
            st_cnt_ff <= nxt_st_cnt;
        end
    end

    // Pattern choice by severity.
    assign minor   = stat_ff.minor_fault | stat_ff.conn_timeout
                   | (stat_ff.any_connected & ~stat_ff.all_connected);
    assign offline = ~stat_ff.online | ~stat_ff.dup_check_done | ~stat_ff.net_power;

    always_comb
    begin
        if (st_ff != NSL_ST_DONE)
            nxt_mode = NSL_M_TEST;
        else if (stat_ff.dup_address | stat_ff.bus_off)
            nxt_mode = NSL_M_RED;
        else if (minor)
            nxt_mode = NSL_M_RFLASH;
        else if (offline)
            nxt_mode = NSL_M_DARK;
        else if (!stat_ff.all_connected)
            nxt_mode = NSL_M_GFLASH;
        else
            nxt_mode = NSL_M_GREEN;
    end

    // Flash phase restarts lit on every pattern change.
    always_comb
    begin
        nxt_phase = phase_ff;
        if (nxt_mode != mode_ff)
            nxt_phase = '0;
        else if (tick_ff)
            nxt_phase = (phase_ff == MS_W'(FLASH_PERIOD_MS - 1)) ? '0 : phase_ff + 1'b1;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            mode_ff  <= NSL_M_TEST;
            phase_ff <= '0;
        end
        else
        begin
            mode_ff  <= nxt_mode;
            phase_ff <= nxt_phase;
        end
    end

    // Indicator drive from pattern and phase.
    assign lit = (phase_ff < MS_W'(FLASH_ON_MS));

    always_comb
    begin
        nxt_led = '0;
        case (mode_ff)
            NSL_M_TEST:
            begin
                nxt_led.green = (st_ff == NSL_ST_GREEN);
                nxt_led.red   = (st_ff == NSL_ST_RED);
            end
            NSL_M_RED:    nxt_led.red   = 1'b1;
            NSL_M_RFLASH: nxt_led.red   = lit;
            NSL_M_GFLASH: nxt_led.green = lit;
            NSL_M_GREEN:  nxt_led.green = 1'b1;
            NSL_M_DARK:   nxt_led       = '0;
            default:      nxt_led       = '0;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            led_ff <= '0;
        else
            led_ff <= nxt_led;
    end

    // Checks of the displayed behaviour.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    steady_green_a: assert property (mode_ff == NSL_M_GREEN |=> led_ff == 2'b10)
        else $error("steady green not shown");
    green_flash_a: assert property (mode_ff == NSL_M_GFLASH |=> led_ff.green == $past(lit) && !led_ff.red)
        else $error("green flash wrong");
    phase_wrap_a: assert property (mode_ff == nxt_mode && tick_ff && phase_ff == MS_W'(FLASH_PERIOD_MS - 1)
                                   |=> phase_ff == '0)
        else $error("flash period wrong");
    phase_range_a: assert property (phase_ff < MS_W'(FLASH_PERIOD_MS))
        else $error("flash phase out of range");
    test_step_a: assert property (st_ff == NSL_ST_GREEN && tick_ff && st_cnt_ff == MS_W'(SELFTEST_MS - 1)
                                  |=> st_ff == NSL_ST_RED ##1 led_ff == 2'b01)
        else $error("self-test step wrong");
    test_green_a: assert property (mode_ff == NSL_M_TEST && st_ff == NSL_ST_GREEN |=> led_ff == 2'b10)
        else $error("self-test green missing");
    red_flash_a: assert property (mode_ff == NSL_M_RFLASH |=> led_ff.red == $past(lit) && !led_ff.green)
        else $error("red flash wrong");
    critical_red_a: assert property (st_ff == NSL_ST_DONE && stat_ff.bus_off
                                     |=> mode_ff == NSL_M_RED ##1 led_ff == 2'b01)
        else $error("critical red not shown");
    dark_off_a: assert property (mode_ff == NSL_M_DARK |=> led_ff == 2'b00)
        else $error("dark state lit");
    steady_hold_a: assert property ((mode_ff == NSL_M_RED) [*2] |-> led_ff.red [*2])
        else $error("steady red interrupted");
    test_first_a: assert property (st_ff != NSL_ST_DONE |=> mode_ff == NSL_M_TEST)
        else $error("self-test not given priority");

    cover_test_end_c: cover property (st_ff == NSL_ST_RED ##1 st_ff == NSL_ST_DONE);
    cover_green_c:    cover property (mode_ff == NSL_M_GREEN);
    cover_rflash_c:   cover property (mode_ff == NSL_M_RFLASH && !lit);
    cover_gflash_c:   cover property (mode_ff == NSL_M_GFLASH && lit);

endmodule : nsl_sequencer
`default_nettype wire

// >>> hw/nsl_pkg.sv
// Package with constants and types of the network status indicator sequencer.
`default_nettype none
package nsl_pkg;

    // Clock and timing figures.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int MS_NS           = 1000000;
    localparam int TICK_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W          = 17;
    localparam int MS_W            = 10;
    localparam int FLASH_ON_MS     = 500;
    localparam int FLASH_PERIOD_MS = 1000;
    localparam int SELFTEST_MS     = 250;
    localparam int TICK_START      = 1; // Tick count after a restart, one ahead for the registered tick.

    // Register offsets and layout.
    localparam logic [11:0] REG_STATUS_OFS = 12'h000;
    localparam logic [11:0] REG_VIEW_OFS   = 12'h004;
    localparam int          STATUS_W       = 9;
    localparam int          VIEW_MODE_LSB  = 0;
    localparam int          VIEW_TEST_BIT  = 3;
    localparam int          VIEW_GREEN_BIT = 4;
    localparam int          VIEW_RED_BIT   = 5;

    // Status bits written by firmware, bit 0 is conn_timeout.
    typedef struct packed {
        logic net_power;
        logic dup_check_done;
        logic online;
        logic all_connected;
        logic any_connected;
        logic dup_address;
        logic bus_off;
        logic minor_fault;
        logic conn_timeout;
    } nsl_status_type;

    localparam nsl_status_type STATUS_RST = 9'h000;

    // Indicator drive pair.
    typedef struct packed {
        logic green;
        logic red;
    } nsl_led_type;

    // Displayed patterns, most severe first.
    typedef enum logic [2:0] {
        NSL_M_TEST,
        NSL_M_RED,
        NSL_M_RFLASH,
        NSL_M_DARK,
        NSL_M_GFLASH,
        NSL_M_GREEN
    } nsl_mode_type;

    // Power-on self-test steps.
    typedef enum logic [1:0] {
        NSL_ST_GREEN,
        NSL_ST_RED,
        NSL_ST_DONE
    } nsl_test_type;

endpackage : nsl_pkg
`default_nettype wire

// >>> sim/nsl_led_model.sv
// Model of the two-colour indicator that times its lit and dark phases.
`timescale 1ns/10ps
`default_nettype none
module nsl_led_model
(
    input  wire logic clk,
    input  wire logic green,
    input  wire logic red,
    output var  int   on_len,
    output var  int   off_len,
    output var  int   changes
);
    logic [1:0] last;
    int         cnt;

    // Starts with the indicator taken as dark and nothing measured.
    initial
    begin
        last = 2'h0;
        cnt = 0;
        on_len = 0;
        off_len = 0;
        changes = 0;
    end

    // Records how long the previous colour pair held each time the pair changes.
    always @(posedge clk)
    begin
        if ({green, red} !== last)
        begin
            if (last != 2'h0)
                on_len <= cnt;
            else
                off_len <= cnt;
            changes <= changes + 1;
            cnt <= 1;
            last <= {green, red};
        end
        else
            cnt <= cnt + 1;
    end
endmodule : nsl_led_model
`default_nettype wire

// >>> sim/test_network_status_led_sequencer.sv
// Self-checking testbench of the network status indicator sequencer.
`timescale 1ns/10ps
`default_nettype none
module test_network_status_led_sequencer;
    import nsl_pkg::*;
    localparam int TC = 4;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        led_green;
    logic        led_red;
    logic [31:0] rd;
    logic        err;
    int          on_len;
    int          off_len;
    int          changes;
    int          c;
    int          errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          tbl[8] = '{32'h1e0, 32'h1c0, 32'h1c2, 32'h1c8, 32'h1d0, 32'h104, 32'h001, 32'h060};
    int          st[3] = '{32'h1e0, 32'h1c8, 32'h000};

    nsl_sequencer #(.TICK_CYC(TC)) i_nsl_sequencer (.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LED_GREEN(led_green), .LED_RED(led_red));
    nsl_led_model i_nsl_led_model (.clk(sys_clk), .green(led_green), .red(led_red), .on_len(on_len),
        .off_len(off_len), .changes(changes));

    // Clock of 10 ns and a cycle ceiling that cuts a hang short.
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors = errors + 1;
            conclude();
        end
    end

    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One APB transfer; the answer is taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // Waits until the indicator has changed a given number of times.
    task automatic wait_to(input int t);
        while (changes < t)
            @(posedge sys_clk);
    endtask : wait_to

    // Pattern expected from a status word, most severe condition first.
    function automatic int mode_of(input int s);
        if (s[3] | s[2])
            return 1;
        if (s[1] | s[0] | (s[4] & !s[5]))
            return 2;
        if (!s[6] | !s[7] | !s[8])
            return 3;
        if (!s[5])
            return 4;
        return 5;
    endfunction : mode_of

    // Writes a status word, then checks the register, the view and the indicator.
    task automatic try_status(input int s);
        int m;
        m = mode_of(s);
        apb(1'b1, 12'h000, s);
        repeat (2) @(posedge sys_clk);
        apb(1'b0, 12'h000, 32'h0);
        chk("status", rd, s & 32'h1ff);
        apb(1'b0, 12'h004, 32'h0);
        chk("mode", rd & 32'hf, m);
        chk("green", led_green, m >= 4);
        chk("red", led_red, m == 1 || m == 2);
    endtask : try_status

    // Writes a flash status from dark and times one lit and one dark phase.
    task automatic flash(input int s, input logic g);
        apb(1'b1, 12'h000, 32'h0);
        repeat (4) @(posedge sys_clk);
        c = changes;
        apb(1'b1, 12'h000, s);
        wait_to(c + 1);
        chk("flash colour", {led_green, led_red}, {g, !g});
        wait_to(c + 2);
        chk("lit", on_len, FLASH_ON_MS * TC);
        wait_to(c + 3);
        chk("dark", off_len, (FLASH_PERIOD_MS - FLASH_ON_MS) * TC);
    endtask : flash

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Main sequence: self-test, status table, random status, refusals, flashes, steadiness.
    initial
    begin
        void'($urandom(43));
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        c = changes;
        apb(1'b1, 12'h000, 32'h1e0);
        wait_to(c + 2);
        chk("test red", led_red, 1'b1);
        chk("test green len", on_len, SELFTEST_MS * TC);
        wait_to(c + 3);
        chk("test red len", on_len, SELFTEST_MS * TC);
        foreach (tbl[i])
            try_status(tbl[i]);
        repeat (12)
            try_status($urandom_range(511, 0));
        apb(1'b1, 12'h004, 32'h0);
        chk("ro write", err, 1'b1);
        apb(1'b1, 12'h00c, 32'h0);
        chk("unmapped", err, 1'b1);
        flash(32'h1c0, 1'b1);
        flash(32'h1c2, 1'b0);
        foreach (st[i])
        begin
            apb(1'b1, 12'h000, st[i]);
            repeat (4) @(posedge sys_clk);
            c = changes;
            repeat (2500) @(posedge sys_clk);
            chk("steady", changes, c);
        end
        conclude();
    end
endmodule : test_network_status_led_sequencer
`default_nettype wire
